/* File: rtl/csc_pkg.sv */
// Shared constants, register layouts and types of the chopper and current-scale block
package csc_pkg;

    // Clock period in ps, then timing counts in system clocks
    localparam int unsigned CLK_PERIOD_PS   = 32'h0000_61A8;
    localparam int unsigned STST_CYCLES_DEF = 32'h0010_0000;
    localparam int unsigned PD_UNIT_DEF     = 32'h0004_0000;
    localparam int unsigned HOLD_UNIT_DEF   = 32'h0004_0000;
    localparam int unsigned FD_UNIT_CYC     = 32'h0000_0020;
    localparam int unsigned SLOW_UNIT_CYC   = 32'h0000_0020;
    localparam int unsigned SLOW_BASE_CYC   = 32'h0000_0018;

    // Current arithmetic
    localparam logic [3:0] OFFSET_ZERO_CODE = 4'h3;
    localparam logic [8:0] GSCALE_FULL      = 9'h100;
    localparam logic [7:0] SINE_AMPL        = 8'hF8;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CUR    = 8'h04;
    localparam logic [7:0] ADDR_PD     = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // Writable bits and reset values
    localparam logic [31:0] CTRL_WMASK = 32'h1F0F_FF0F;
    localparam logic [31:0] CUR_WMASK  = 32'h0F1F_1FFF;
    localparam logic [31:0] PD_WMASK   = 32'h0000_00FF;
    localparam logic [31:0] CTRL_RST   = 32'h0003_4401;
    localparam logic [31:0] CUR_RST    = 32'h0410_1F00;
    localparam logic [31:0] PD_RST     = 32'h0000_000A;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [2:0] rsv3;
        logic [4:0] adapt_scale;
        logic [3:0] rsv2;
        logic [3:0] hyst_end_field;
        logic [3:0] fast_decay_time;
        logic [3:0] slow_decay_time;
        logic [3:0] rsv1;
        logic       adapt_en;
        logic       fullstep_active;
        logic       fd_cmp_disable;
        logic       chm;
    } csc_ctrl_t;

    typedef struct packed {
        logic [3:0] rsv3;
        logic [3:0] hold_ramp_step_delay;
        logic [2:0] rsv2;
        logic [4:0] hold_current_scale;
        logic [2:0] rsv1;
        logic [4:0] run_current_scale;
        logic [7:0] global_current_scaler;
    } csc_cur_t;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_ON   = 2'b01,
        CH_FAST = 2'b10,
        CH_SLOW = 2'b11
    } csc_chop_t;

    typedef struct packed {
        logic [20:0] rsv2;
        csc_chop_t   chop;
        logic        stst;
        logic [2:0]  rsv1;
        logic [4:0]  cs;
    } csc_stat_t;

endpackage : csc_pkg

/* File: rtl/csc_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module csc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : csc_sync

/* File: rtl/csc_top.sv */
// Constant off-time chopper and motor current scaling with AXI4-Lite registers
// Functional notes
// RULE_01: After each on phase apply fast decay of fixed programmed length.
// RULE_02: On phase ends when the target comparator reports current reached.
// RULE_03: Fullstep operation forces the constant off-time chopper regardless of mode.
// RULE_04: Fast decay time field: zero means slow decay only, else longer fast decay.
// RULE_05: Offset field adds code minus three to target current when mode is one.
// RULE_06: Comparator may end fast decay early unless the disable bit is set.
// RULE_07: Global scaler in 1/256 steps; zero means full scale 256.
// RULE_08: Keep a host-readable 5-bit current scale from run, hold and adaptive control.
// RULE_09: Target equals scaler/256 times sine/248 times (scale+1)/32.
// RULE_10: While running the scale is the run setting, factor (n+1)/32.
// RULE_11: Run setting caps the scale chosen by adaptive current control.
// RULE_12: At standstill the scale is the hold setting, same encoding.
// RULE_13: Entering standstill, scale drops one step per hold delay times 2^18 clocks.
// RULE_14: Hold delay zero jumps to hold; ramp starts after the power-down wait.
// RULE_15: Host should keep run scale between 16 and 31 for fine microsteps.
// RULE_16: Standstill flag rises 2^20 clocks after the last step pulse.
// RULE_17: Power-down wait: zero none, one minimal, each further step 2^18 clocks.
// RULE_18: Run or hold level is selected by the standstill flag.
// RULE_19: Ramp decrements by one until hold; a step restores run immediately.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module csc_top
    import csc_pkg::*;
#(
    parameter int unsigned STST_CYCLES = STST_CYCLES_DEF,
    parameter int unsigned PD_UNIT     = PD_UNIT_DEF,
    parameter int unsigned HOLD_UNIT   = HOLD_UNIT_DEF
) (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // AXI4-Lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Pins: step pulse and chopper comparators
    input  wire logic        STEP,
    input  wire logic        CMP_TARGET,
    input  wire logic        CMP_NEG,
    // Sine table value from the sequencer, same clock
    input  wire logic [7:0]  SINE_VAL,
    // Bridge control and current outputs
    output logic             BRIDGE_ON,
    output logic             BRIDGE_FAST,
    output logic             BRIDGE_SLOW,
    output logic [22:0]      TARGET_CUR,
    output logic [4:0]       CUR_SCALE,
    output logic             STANDSTILL
);
    logic [31:0] ctrl_q, cur_q, pd_q;
    csc_ctrl_t   ctrl;
    csc_cur_t    cur;
    assign ctrl = csc_ctrl_t'(ctrl_q);
    assign cur  = csc_cur_t'(cur_q);

    // Pin synchronisation
    logic [2:0] pins_s;
    logic       step_s, cmp_on_s, cmp_neg_s, step_prev_q, step_edge;
    csc_sync #(.W(3)) u_sync (
        .clk   (SYS_CLK),
        .rst_n (NRST),
        .d     ({STEP, CMP_TARGET, CMP_NEG}),
        .q     (pins_s)
    );
    assign {step_s, cmp_on_s, cmp_neg_s} = pins_s;
    assign step_edge = step_s && !step_prev_q;

    // AXI4-Lite write path
    logic        aw_held_q, w_held_q, wr_fire, wr_hit;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic [31:0] bytemask;
    assign wr_fire  = aw_held_q && w_held_q && !S_AXI_BVALID;
    assign wr_hit   = ({awaddr_q[7:2], 2'h0} == ADDR_CTRL) ||
                      ({awaddr_q[7:2], 2'h0} == ADDR_CUR) ||
                      ({awaddr_q[7:2], 2'h0} == ADDR_PD);
    assign bytemask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] bm, input logic [31:0] wm);
        merge = ((old & ~bm) | (nw & bm)) & wm;
    endfunction : merge

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held_q     <= 1'b1;
                wdata_q      <= S_AXI_WDATA;
                wstrb_q      <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            // Ready again only once the response is taken: one write in flight
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= CTRL_RST;
            cur_q  <= CUR_RST;
            pd_q   <= PD_RST;
        end else if (wr_fire) begin
            case ({awaddr_q[7:2], 2'h0})
                ADDR_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, bytemask, CTRL_WMASK);
                ADDR_CUR:  cur_q  <= merge(cur_q, wdata_q, bytemask, CUR_WMASK);
                ADDR_PD:   pd_q   <= merge(pd_q, wdata_q, bytemask, PD_WMASK);
                default:   ;
            endcase
        end
    end

    // AXI4-Lite read path
    csc_chop_t   state_q, state_d;
    logic        stst_q;
    logic [4:0]  cs_q;
    csc_stat_t   stat;
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        stat      = '0;
        stat.cs   = cs_q;  // RULE_08
        stat.stst = stst_q;
        stat.chop = state_q;
        rd_hit    = 1'b1;
        case ({S_AXI_ARADDR[7:2], 2'h0})
            ADDR_CTRL:   rd_word = ctrl_q;
            ADDR_CUR:    rd_word = cur_q;
            ADDR_PD:     rd_word = pd_q;
            ADDR_STATUS: rd_word = stat;
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rd_word;
            S_AXI_RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Constant off-time chopper
    logic       chop_en, tmr_clr;
    logic [9:0] tmr_q, fast_len, slow_len;
    assign chop_en  = ctrl.chm || ctrl.fullstep_active;  // RULE_03
    assign fast_len = 10'(ctrl.fast_decay_time * FD_UNIT_CYC);  // RULE_04
    assign slow_len = 10'(ctrl.slow_decay_time * SLOW_UNIT_CYC + SLOW_BASE_CYC);

    always_comb begin
        state_d = state_q;
        case (state_q)
            CH_IDLE: state_d = CH_ON;
            CH_ON: if (cmp_on_s) begin  // RULE_02
                state_d = (ctrl.fast_decay_time == 4'h0) ? CH_SLOW : CH_FAST;  // RULE_04
            end
            CH_FAST: if (tmr_q == fast_len - 10'h001 ||  // RULE_01
                         (!ctrl.fd_cmp_disable && cmp_neg_s)) begin  // RULE_06
                state_d = CH_SLOW;
            end
            CH_SLOW: if (tmr_q == slow_len - 10'h001) begin
                state_d = CH_ON;
            end
            default: state_d = CH_IDLE;
        endcase
        // The other chopper mode lives elsewhere; this one idles without it
        if (!chop_en) begin
            state_d = CH_IDLE;
        end
    end
    assign tmr_clr = (state_d != state_q);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state_q     <= CH_IDLE;
            tmr_q       <= 10'h000;
            BRIDGE_ON   <= 1'b0;
            BRIDGE_FAST <= 1'b0;
            BRIDGE_SLOW <= 1'b0;
        end else begin
            state_q     <= state_d;
            tmr_q       <= tmr_clr ? 10'h000 : tmr_q + 10'h001;
            BRIDGE_ON   <= (state_d == CH_ON);
            BRIDGE_FAST <= (state_d == CH_FAST);
            BRIDGE_SLOW <= (state_d == CH_SLOW);
        end
    end

    // Commanded current
    logic [8:0]  gs_eff;
    logic [9:0]  sine_sum;
    logic [7:0]  sine_adj;
    logic [22:0] target_d;
    assign gs_eff = (cur.global_current_scaler == 8'h00) ? GSCALE_FULL :  // RULE_07
                    {1'b0, cur.global_current_scaler};
    always_comb begin
        sine_sum = {2'h0, SINE_VAL};
        if (ctrl.chm) begin  // RULE_05
            sine_sum = {2'h0, SINE_VAL} + {6'h00, ctrl.hyst_end_field} -
                       {6'h00, OFFSET_ZERO_CODE};
        end
        // Clamp: a negative offset near zero must not wrap to full current
        if (sine_sum[9]) begin
            sine_adj = 8'h00;
        end else if (sine_sum[8]) begin
            sine_adj = 8'hFF;
        end else begin
            sine_adj = sine_sum[7:0];
        end
        target_d = 23'(sine_adj * gs_eff * ({1'b0, cs_q} + 6'h01));  // RULE_09
    end

    // Standstill detection
    logic [31:0] idle_cnt_q, pd_cnt_q, pd_len, ramp_cnt_q, ramp_len;
    logic        pd_done_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            step_prev_q <= 1'b0;
            idle_cnt_q  <= 32'h0000_0000;
            stst_q      <= 1'b0;
        end else begin
            step_prev_q <= step_s;
            if (step_edge) begin
                idle_cnt_q <= 32'h0000_0000;
            end else if (!stst_q) begin
                idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
            end
            stst_q <= !step_edge && (stst_q || idle_cnt_q == STST_CYCLES - 1);  // RULE_16
        end
    end

    // Power-down wait, then run-to-hold ramp
    assign pd_len   = (pd_q[7:0] == 8'h00) ? 32'h0000_0000 :  // RULE_17
                      32'({24'h000000, pd_q[7:0] - 8'h01} * PD_UNIT + 1);
    assign ramp_len = 32'({28'h0000000, cur.hold_ramp_step_delay} * HOLD_UNIT);

    logic [4:0] run_eff;
    assign run_eff = (ctrl.adapt_en && ctrl.adapt_scale < cur.run_current_scale) ?  // RULE_11
                     ctrl.adapt_scale : cur.run_current_scale;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pd_cnt_q   <= 32'h0000_0000;
            pd_done_q  <= 1'b0;
            ramp_cnt_q <= 32'h0000_0000;
            cs_q       <= 5'h00;
        end else if (step_edge || !stst_q) begin  // RULE_18
            pd_cnt_q   <= 32'h0000_0000;
            pd_done_q  <= 1'b0;
            ramp_cnt_q <= 32'h0000_0000;
            cs_q       <= run_eff;  // RULE_10 RULE_19
        end else if (!pd_done_q) begin
            pd_cnt_q  <= pd_cnt_q + 32'h0000_0001;
            pd_done_q <= (pd_cnt_q + 32'h0000_0001 >= pd_len);  // RULE_14
        end else if (cur.hold_ramp_step_delay == 4'h0 || cs_q <= cur.hold_current_scale) begin
            cs_q <= cur.hold_current_scale;  // RULE_12 RULE_14
        end else if (ramp_cnt_q == ramp_len - 1) begin
            ramp_cnt_q <= 32'h0000_0000;
            cs_q       <= cs_q - 5'h01;  // RULE_13 RULE_19
        end else begin
            ramp_cnt_q <= ramp_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            TARGET_CUR <= 23'h000000;
            CUR_SCALE  <= 5'h00;
            STANDSTILL <= 1'b0;
        end else begin
            TARGET_CUR <= target_d;
            CUR_SCALE  <= cs_q;
            STANDSTILL <= stst_q;
        end
    end

    // Checks
    logic [9:0] phase_cnt_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            phase_cnt_q <= 10'h000;
        end else begin
            phase_cnt_q <= tmr_clr ? 10'h001 : phase_cnt_q + 10'h001;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sequence s_ramp_active;
        stst_q && pd_done_q && cur.hold_ramp_step_delay != 4'h0;
    endsequence
    sequence s_fast_timed_exit;
        state_q == CH_FAST && state_d == CH_SLOW && ctrl.fd_cmp_disable && chop_en;
    endsequence

    a_fast_length: assert property (s_fast_timed_exit |-> phase_cnt_q == fast_len) // RULE_01
        else $error("fast decay length differs from setting");
    a_on_end: assert property (state_q == CH_ON && cmp_on_s && chop_en |=> state_q != CH_ON) // RULE_02
        else $error("on phase did not end on comparator");
    a_force_mode: assert property (ctrl.fullstep_active && state_q == CH_IDLE |=> state_q == CH_ON) // RULE_03
        else $error("fullstep did not start chopper");
    a_slow_only: assert property (state_q == CH_ON && cmp_on_s && chop_en &&
        ctrl.fast_decay_time == 4'h0 |=> state_q == CH_SLOW) // RULE_04
        else $error("zero fast decay time still used fast decay");
    a_early_end: assert property (state_q == CH_FAST && chop_en && !ctrl.fd_cmp_disable &&
        cmp_neg_s |=> state_q == CH_SLOW) // RULE_06
        else $error("comparator did not end fast decay");
    a_offset_max: assert property (ctrl.chm && ctrl.hyst_end_field == 4'hF && SINE_VAL == 8'h00 &&
        cur.global_current_scaler == 8'h00 && cs_q == 5'h1F |=> TARGET_CUR == 23'h018000) // RULE_05
        else $error("offset code 15 is not plus 12");
    a_full_scale: assert property (!ctrl.chm && cur.global_current_scaler == 8'h00 &&
        cs_q == 5'h1F |=> TARGET_CUR == {2'h0, $past(SINE_VAL), 13'h0000}) // RULE_07 RULE_09
        else $error("scaler zero is not full scale");
    a_stst_time: assert property (stst_q == (idle_cnt_q >= STST_CYCLES)) // RULE_16
        else $error("standstill flag timing wrong");
    a_run_scale: assert property (!stst_q ##1 !stst_q |-> cs_q == $past(run_eff) &&
        cs_q <= $past(cur.run_current_scale)) // RULE_10 RULE_11
        else $error("running scale is not run setting");
    a_step_run: assert property (step_edge |=> cs_q == $past(run_eff) && !stst_q) // RULE_19
        else $error("step did not restore run scale");
    a_ramp_step: assert property (s_ramp_active ##1 stst_q && cs_q != $past(cs_q) |->
        cs_q == $past(cs_q) - 5'h01 || cs_q == cur.hold_current_scale) // RULE_13
        else $error("ramp moved by more than one step");
    a_hold_jump: assert property (stst_q && pd_done_q && cur.hold_ramp_step_delay == 4'h0
        |=> !stst_q || cs_q == $past(cur.hold_current_scale)) // RULE_14 RULE_12
        else $error("zero hold delay did not jump to hold");
    a_hold_wait: assert property (stst_q && !pd_done_q && $past(stst_q) |-> cs_q == $past(cs_q)) // RULE_17
        else $error("scale changed during power-down wait");
endmodule : csc_top

/* File: testbench/csc_bridge_model.sv */
// Bridge and coil model that answers the chopper with comparator levels
`timescale 1ns/1ps
module csc_bridge_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bridge phase from the block, test knobs
    input  wire logic       on,
    input  wire logic       fast,
    input  wire logic       neg_early,
    input  wire logic [7:0] on_len,
    // Comparator outputs
    output logic            cmp_target,
    output logic            cmp_neg
);
    int on_cnt;
    int fast_cnt;

    // Current builds while on; negative crossing only when the bench asks for it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_cnt     <= 0;
            fast_cnt   <= 0;
            cmp_target <= 1'b0;
            cmp_neg    <= 1'b0;
        end else begin
            on_cnt     <= on ? on_cnt + 1 : 0;
            fast_cnt   <= fast ? fast_cnt + 1 : 0;
            cmp_target <= on && on_cnt >= int'(on_len);
            cmp_neg    <= fast && neg_early && fast_cnt >= 20;
        end
    end
endmodule : csc_bridge_model

/* File: testbench/const_off_chopper_current_scale_bench.sv */
// Self-checking bench for the chopper and current-scale block
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module const_off_chopper_current_scale_bench import csc_pkg::*;;
    logic        SYS_CLK = 0, NRST = 0, STEP = 0, neg_early = 0, CMP_TARGET, CMP_NEG;
    logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0, S_AXI_AWREADY, S_AXI_WREADY;
    logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, BRIDGE_ON, BRIDGE_FAST;
    logic        BRIDGE_SLOW, STANDSTILL;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
    logic [3:0]  S_AXI_WSTRB = 4'hF;
    logic [4:0]  CUR_SCALE;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, SINE_VAL = 8'h64;
    logic [22:0] TARGET_CUR;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
    int          failures = 0, n_compared = 0;

    csc_bridge_model BFM (.clk(SYS_CLK), .rst_n(NRST), .on(BRIDGE_ON), .fast(BRIDGE_FAST),
        .neg_early(neg_early), .on_len(8'h1E), .cmp_target(CMP_TARGET), .cmp_neg(CMP_NEG));
    // Short counts keep the standstill ramp within a few thousand cycles
    csc_top #(.STST_CYCLES(64), .PD_UNIT(16), .HOLD_UNIT(8)) DUT (.SYS_CLK, .NRST,
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY, .STEP, .CMP_TARGET, .CMP_NEG, .SINE_VAL,
        .BRIDGE_ON, .BRIDGE_FAST, .BRIDGE_SLOW, .TARGET_CUR, .CUR_SCALE, .STANDSTILL);
    always #12.5 SYS_CLK = ~SYS_CLK;

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic hang;
        failures++;
        final_report();
    endtask : hang
    function automatic logic [31:0] ctl(logic chm, dis, fs, logic [3:0] fd, ofs);
        return {12'h000, ofs, fd, 4'h4, 5'h00, fs, dis, chm};
    endfunction : ctl
    function automatic logic [31:0] cur(logic [7:0] gs, logic [4:0] run, hold, logic [3:0] d);
        return {4'h0, d, 3'h0, hold, 3'h0, run, gs};
    endfunction : cur
    // Ready is registered, so sampling it mid-cycle matches the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 0, w = 0, ta, tw;
        int n;
        @(posedge SYS_CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (n = 0; n < 99 && !(aw && w); n++) begin
            @(negedge SYS_CLK);
            ta = S_AXI_AWREADY === 1'b1;
            tw = S_AXI_WREADY === 1'b1;
            @(posedge SYS_CLK);
            if (ta) S_AXI_AWVALID <= 1'b0;
            if (tw) S_AXI_WVALID <= 1'b0;
            aw |= ta;
            w |= tw;
        end
        n = 0;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (S_AXI_BVALID !== 1'b1 && n < 99);
        resp = S_AXI_BRESP;
        @(posedge SYS_CLK);
        S_AXI_BREADY <= 1'b0;
        if (n == 99 || !aw || !w) hang();
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge SYS_CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (S_AXI_ARREADY !== 1'b1 && n < 99);
        @(posedge SYS_CLK);
        S_AXI_ARVALID <= 1'b0;
        do begin
            @(negedge SYS_CLK);
            n++;
        end while (S_AXI_RVALID !== 1'b1 && n < 199);
        rd = S_AXI_RDATA;
        resp = S_AXI_RRESP;
        @(posedge SYS_CLK);
        S_AXI_RREADY <= 1'b0;
        if (n >= 199) hang();
    endtask : rdr
    task automatic pulse;
        @(posedge SYS_CLK);
        STEP <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        STEP <= 1'b0;
        repeat (4) @(negedge SYS_CLK);
    endtask : pulse
    // One on, fast and slow phase; a first call may catch a partial one
    task automatic meas(output int t_on, t_fast, t_slow);
        int n;
        for (n = 0; n < 3000 && BRIDGE_ON !== 1'b1; n++) @(negedge SYS_CLK);
        for (t_on = 0; t_on < 3000 && BRIDGE_ON === 1'b1; t_on++) @(negedge SYS_CLK);
        for (t_fast = 0; t_fast < 3000 && BRIDGE_FAST === 1'b1; t_fast++) @(negedge SYS_CLK);
        for (t_slow = 0; t_slow < 3000 && BRIDGE_SLOW === 1'b1; t_slow++) @(negedge SYS_CLK);
        if (n == 3000 || t_slow == 3000) hang();
    endtask : meas

    task automatic t_regs;
        rdr(ADDR_CTRL);
        `CHK(rd, CTRL_RST)
        rdr(ADDR_CUR);
        `CHK(rd, CUR_RST)
        rdr(8'h10);
        `CHK({resp, rd}, {RESP_SLVERR, 32'h0000_0000})
        wr(ADDR_STATUS, 32'hFFFF_FFFF);
        `CHK(resp, RESP_SLVERR)
        wr(ADDR_PD, 32'hFFFF_FFFF);
        rdr(ADDR_PD);
        `CHK(rd, PD_WMASK)
        wr(ADDR_PD, PD_RST);
    endtask : t_regs
    task automatic t_chop;
        int a, f, s;
        logic [3:0] fds [4] = '{4'h0, 4'h1, 4'h4, 4'hF};
        foreach (fds[i]) begin
            wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, fds[i], 4'h3));
            meas(a, f, s);
            meas(a, f, s);
            `CHK(f, int'(fds[i]) * 32)
            `CHK(s, 152)
            `CHK(a > 30 && a < 40, 1'b1)
        end
        wr(ADDR_CTRL, ctl(1'b1, 1'b0, 1'b0, 4'h4, 4'h3));
        neg_early <= 1'b1;
        meas(a, f, s);
        meas(a, f, s);
        `CHK(f > 0 && f < 64, 1'b1)
        wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h4, 4'h3));
        meas(a, f, s);
        meas(a, f, s);
        `CHK(f, 128)
        wr(ADDR_CTRL, ctl(1'b0, 1'b1, 1'b1, 4'h4, 4'h3));
        neg_early <= 1'b0;
        meas(a, f, s);
        meas(a, f, s);
        `CHK(f, 128)
        wr(ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h4, 4'h3));
        repeat (10) @(negedge SYS_CLK);
        `CHK({BRIDGE_ON, BRIDGE_FAST, BRIDGE_SLOW}, 3'h0)
    endtask : t_chop
    task automatic t_cur;
        wr(ADDR_CUR, cur(8'h00, 5'h1F, 5'h1F, 4'h4));
        pulse();
        `CHK(TARGET_CUR, 23'h64 * 23'h100 * 23'h20)
        wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h4, 4'h7));
        wr(ADDR_CUR, cur(8'h80, 5'h0F, 5'h0F, 4'h4));
        pulse();
        `CHK(TARGET_CUR, 23'h68 * 23'h80 * 23'h10)
        `CHK(CUR_SCALE, 5'h0F)
        wr(ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'h4, 4'h0));
        repeat (4) @(negedge SYS_CLK);
        `CHK(TARGET_CUR, 23'h61 * 23'h80 * 23'h10)
        wr(ADDR_CTRL, 32'h1F0F_4409);
        pulse();
        `CHK(CUR_SCALE, 5'h0F)
    endtask : t_cur
    task automatic t_stst;
        int n, gap = 0;
        logic [4:0] prev;
        wr(ADDR_CUR, cur(8'h00, 5'h1F, 5'h10, 4'h4));
        SINE_VAL <= 8'h00;
        pulse();
        `CHK(CUR_SCALE, 5'h1F)
        `CHK(TARGET_CUR, 23'h018000)
        rdr(ADDR_STATUS);
        `CHK(rd[4:0], 5'h1F)
        for (n = 0; n < 99 && STANDSTILL !== 1'b1; n++) @(negedge SYS_CLK);
        `CHK(n > 40 && n < 70, 1'b1)
        prev = CUR_SCALE;
        for (n = 0; n < 2000 && CUR_SCALE !== 5'h10; n++) begin
            @(negedge SYS_CLK);
            gap++;
            if (CUR_SCALE !== prev) begin
                `CHK(CUR_SCALE, prev - 5'h01)
                if (prev != 5'h1F) `CHK(gap, 32)
                prev = CUR_SCALE;
                gap = 0;
            end
        end
        `CHK(CUR_SCALE, 5'h10)
        wr(ADDR_CUR, cur(8'h00, 5'h1F, 5'h10, 4'h0));
        pulse();
        `CHK({STANDSTILL, CUR_SCALE}, 6'h1F)
        for (n = 0; n < 99 && STANDSTILL !== 1'b1; n++) @(negedge SYS_CLK);
        for (n = 0; n < 400 && CUR_SCALE === 5'h1F; n++) @(negedge SYS_CLK);
        `CHK(CUR_SCALE, 5'h10)
        `CHK(n > 140 && n < 152, 1'b1)
    endtask : t_stst

    initial begin
        repeat (6) @(posedge SYS_CLK);
        NRST <= 1'b1;
        t_regs();
        t_chop();
        t_cur();
        t_stst();
        final_report();
    end
endmodule : const_off_chopper_current_scale_bench
